// ===== uab_regs.svh
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

// widths
`define UAB_AW          3
`define UAB_DW          16
`define UAB_DIVW        13
`define UAB_CHW         9
`define UAB_NFLAG       10
`define UAB_MASKW       8

// register offsets
`define UAB_A_BDH       3'h0
`define UAB_A_BDL       3'h1
`define UAB_A_CTL1      3'h2
`define UAB_A_CTL2      3'h3
`define UAB_A_STAT      3'h4
`define UAB_A_MASK      3'h5
`define UAB_A_DATA      3'h6
`define UAB_A_DIVR      3'h7

// high divisor register fields
`define UAB_BDH_BRK_IE  7
`define UAB_BDH_EDGE_IE 6
`define UAB_BDH_DIVH    4

// control 1 fields
`define UAB_C1_NINE     4
`define UAB_C1_WAKE     3
`define UAB_C1_INV      2
`define UAB_C1_PAR      1
`define UAB_C1_ODD      0
`define UAB_C1_MSB      4

// control 2 fields
`define UAB_C2_TX_ON    3
`define UAB_C2_RX_ON    2
`define UAB_C2_SLEEP    1
`define UAB_C2_BRK      0

// status flag positions
`define UAB_F_TDRE      0
`define UAB_F_TC        1
`define UAB_F_RDRF      2
`define UAB_F_OR        3
`define UAB_F_NF        4
`define UAB_F_FE        5
`define UAB_F_PF        6
`define UAB_F_IDLE      7
`define UAB_F_EDGE      8
`define UAB_F_BRK       9

// reset values
`define UAB_BDL_RST     8'h04
`define UAB_DIV_RST     13'h0004

// timing in oversample ticks and bit counts
`define UAB_SUB_LAST    4'hF
`define UAB_SMP_A       4'h7
`define UAB_SMP_B       4'h8
`define UAB_SMP_C       4'h9
`define UAB_BITS8       4'hA
`define UAB_BITS9       4'hB
`define UAB_STOP8       4'h9
`define UAB_STOP9       4'hA
`define UAB_BRK_TX      4'hD
`define UAB_BRK_RX      8'hB0
`define UAB_IDLE8       8'hA0
`define UAB_IDLE9       8'hB0
`define UAB_RUN_MAX     8'hFF

`endif

// ===== uab_pkg.sv
`include "uab_regs.svh"
package uab_pkg;

    typedef logic [`UAB_DW-1:0] uab_word_t;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'h1,
        TX_SHIFT = 2'h2
    } uab_tx_st_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h1,
        RX_BUSY = 2'h2
    } uab_rx_st_t;

    typedef struct packed {
        logic [`UAB_DIVW-1:0] cnt;
        logic                 tick;
    } uab_baud_st_t;

    typedef struct packed {
        logic                   brk_ie;
        logic                   edge_ie;
        logic [`UAB_BDH_DIVH:0] div_hi_buf;
        logic [7:0]             div_lo;
        logic [`UAB_DIVW-1:0]   divisor;
        logic [`UAB_C1_MSB:0]   ctl1;
        logic                   tx_on;
        logic                   rx_on;
        logic                   sleep;
        logic                   brk_req;
        logic [`UAB_NFLAG-1:0]  stat;
        logic [`UAB_MASKW-1:0]  mask;
        logic [`UAB_CHW-1:0]    tx_hold;
        logic                   tx_full;
        uab_tx_st_t             tx_st;
        logic [10:0]            tx_sh;
        logic [3:0]             tx_cnt;
        logic [3:0]             tx_sub;
        logic                   txd;
        logic [1:0]             rx_sync;
        logic                   rx_prev;
        uab_rx_st_t             rx_st;
        logic [3:0]             rx_sub;
        logic [3:0]             rx_idx;
        logic [1:0]             rx_ones;
        logic                   rx_noise;
        logic [`UAB_CHW-1:0]    rx_sh;
        logic [`UAB_CHW-1:0]    rx_data;
        logic                   rx_full;
        logic [7:0]             run;
        logic                   idle_arm;
        uab_word_t              rd_data;
        logic                   irq;
    } uab_state_t;

endpackage

// ===== uab_baud.sv
`timescale 1ns/100ps
`include "uab_regs.svh"
module uab_baud
    import uab_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // control
    input  wire logic                 run,
    input  wire logic [`UAB_DIVW-1:0] divisor,
    // oversample tick
    output logic                      tick
);

    uab_baud_st_t s_reg;
    uab_baud_st_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        // zero divisor holds the counter at zero, no toggling
        if (!run || divisor == '0) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt >= divisor - `UAB_DIVW'(1)) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + `UAB_DIVW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_zero_stop: assert property (
        (divisor == '0) |=> !tick)
        else $error("tick while divisor is zero");

    a_tick_gap: assert property (
        (tick && ce && divisor > `UAB_DIVW'(1)) |=> !tick)
        else $error("tick longer than one cycle");

endmodule

// ===== uab_top.sv
`timescale 1ns/100ps
`include "uab_regs.svh"
// What this block does
// - one divider per module, shared by its transmitter and receiver
// - divisor is 13 bits: high five bits plus low byte
// - high byte write is buffered; low byte write loads both
// - low byte resets non-zero; divider idles until an enable is set
// - zero divisor stops the divider completely
// - divisors 1..8191 give bit rate clock over sixteen times divisor
// - break-detect interrupt enable gates the break flag onto irq
// - receive-edge interrupt enable gates the edge flag onto irq
// - holding plus shift register on both paths, separate enables
// - full duplex NRZ, eight or nine data bits
// - sends thirteen-bit break, detects eleven-bit-time break
// - hardware parity generated on send, checked on receive
// - transmit output polarity selectable
// - status flags for all transmit, receive, error and line events
// - receiver sleeps; wakes on idle line or address mark
// - start, data lsb first, optional ninth bit, stop
// - parity sits in the data msb; zero even, one odd
module uab_top
    import uab_pkg::*;
(
    // clock, reset, freeze
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // register port
    input  wire logic [`UAB_AW-1:0]  addr,
    input  wire logic [`UAB_DW-1:0]  wr_data,
    input  wire logic                wr_en,
    input  wire logic                rd_en,
    output logic      [`UAB_DW-1:0]  rd_data,
    // serial line
    input  wire logic                rxd_pin,
    output logic                     txd_pin,
    // interrupt
    output logic                     irq
);

    uab_state_t s_reg;
    uab_state_t s_next;
    logic       baud_tick;
    logic       line;

    function automatic logic par_bit(input logic [`UAB_CHW-1:0] v,
                                     input logic odd);
        return (^v) ^ odd;
    endfunction

    assign line = s_reg.rx_sync[1];

    // each module owns its divider
    uab_baud uab_baud_i (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .run     (s_reg.tx_on | s_reg.rx_on),
        .divisor (s_reg.divisor),
        .tick    (baud_tick)
    );

    always_comb begin
        logic [`UAB_NFLAG-1:0] set_f;
        logic [`UAB_NFLAG-1:0] clr_f;
        logic [1:0]            ones;
        logic                  bitv;
        logic                  noisy;
        logic                  nine;
        logic                  msb;
        logic [`UAB_CHW-1:0]   d;
        logic [3:0]            stop_ix;
        logic [7:0]            idle_ticks;
        set_f = '0;
        clr_f = '0;
        ones = '0;
        bitv = 1'b0;
        noisy = 1'b0;
        nine = s_reg.ctl1[`UAB_C1_NINE];
        msb = 1'b0;
        d = '0;
        stop_ix = nine ? `UAB_STOP9 : `UAB_STOP8;
        idle_ticks = nine ? `UAB_IDLE9 : `UAB_IDLE8;
        s_next = s_reg;
        s_next.rx_sync = {s_reg.rx_sync[0], rxd_pin};
        s_next.rd_data = '0;

        if (wr_en) begin
            case (addr)
                `UAB_A_BDH: begin
                    s_next.brk_ie  = wr_data[`UAB_BDH_BRK_IE];
                    s_next.edge_ie = wr_data[`UAB_BDH_EDGE_IE];
                    // held until the low byte arrives
                    s_next.div_hi_buf = wr_data[`UAB_BDH_DIVH:0];
                end
                `UAB_A_BDL: begin
                    s_next.div_lo  = wr_data[7:0];
                    s_next.divisor = {s_reg.div_hi_buf,
                                      wr_data[7:0]};
                end
                `UAB_A_CTL1: s_next.ctl1 = wr_data[`UAB_C1_MSB:0];
                `UAB_A_CTL2: begin
                    s_next.tx_on   = wr_data[`UAB_C2_TX_ON];
                    s_next.rx_on   = wr_data[`UAB_C2_RX_ON];
                    s_next.sleep   = wr_data[`UAB_C2_SLEEP];
                    s_next.brk_req = wr_data[`UAB_C2_BRK];
                end
                `UAB_A_STAT: clr_f = wr_data[`UAB_NFLAG-1:0];
                `UAB_A_MASK: s_next.mask = wr_data[`UAB_MASKW-1:0];
                `UAB_A_DATA: begin
                    // a write into a full holding register is dropped
                    if (!s_reg.tx_full) begin
                        s_next.tx_hold = wr_data[`UAB_CHW-1:0];
                        s_next.tx_full = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        if (rd_en) begin
            case (addr)
                `UAB_A_BDH: s_next.rd_data = uab_word_t'({s_reg.brk_ie,
                    s_reg.edge_ie, 1'b0, s_reg.div_hi_buf});
                `UAB_A_BDL: s_next.rd_data = uab_word_t'(s_reg.div_lo);
                `UAB_A_CTL1: s_next.rd_data = uab_word_t'(s_reg.ctl1);
                `UAB_A_CTL2: s_next.rd_data = uab_word_t'({s_reg.tx_on,
                    s_reg.rx_on, s_reg.sleep, s_reg.brk_req});
                `UAB_A_STAT: s_next.rd_data = uab_word_t'(s_reg.stat);
                `UAB_A_MASK: s_next.rd_data = uab_word_t'(s_reg.mask);
                `UAB_A_DATA: begin
                    s_next.rd_data = uab_word_t'(s_reg.rx_data);
                    s_next.rx_full = 1'b0;
                end
                `UAB_A_DIVR: s_next.rd_data = uab_word_t'(s_reg.divisor);
                default: s_next.rd_data = '0;
            endcase
        end

        // transmitter
        unique case (s_reg.tx_st)
            TX_IDLE: begin
                if (s_reg.tx_on && s_reg.brk_req) begin
                    s_next.tx_sh  = '0;
                    s_next.tx_cnt = `UAB_BRK_TX;
                    s_next.tx_sub = '0;
                    s_next.tx_st  = TX_SHIFT;
                end else if (s_reg.tx_on && s_reg.tx_full) begin
                    d = s_reg.tx_hold;
                    if (s_reg.ctl1[`UAB_C1_PAR] && nine) begin
                        d[8] = par_bit({1'b0, d[7:0]},
                            s_reg.ctl1[`UAB_C1_ODD]);
                    end else if (s_reg.ctl1[`UAB_C1_PAR]) begin
                        d[7] = par_bit({2'h0, d[6:0]},
                            s_reg.ctl1[`UAB_C1_ODD]);
                    end
                    s_next.tx_sh = nine ? {1'b1, d, 1'b0}
                                        : {2'h3, d[7:0], 1'b0};
                    s_next.tx_cnt = nine ? `UAB_BITS9 : `UAB_BITS8;
                    s_next.tx_sub = '0;
                    s_next.tx_full = 1'b0;
                    set_f[`UAB_F_TDRE] = 1'b1;
                    s_next.tx_st = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (baud_tick) begin
                    s_next.tx_sub = s_reg.tx_sub + 4'h1;
                    if (s_reg.tx_sub == `UAB_SUB_LAST) begin
                        // break frames keep shifting in zeros
                        s_next.tx_sh  = {|s_reg.tx_sh, s_reg.tx_sh[10:1]};
                        s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
                        if (s_reg.tx_cnt == 4'h1) begin
                            s_next.tx_st = TX_IDLE;
                            if (!s_reg.tx_full && !s_reg.brk_req) begin
                                set_f[`UAB_F_TC] = 1'b1;
                            end
                        end
                    end
                end
            end
            default: s_next.tx_st = TX_IDLE;
        endcase
        if (!s_reg.tx_on) begin
            s_next.tx_st = TX_IDLE;
        end
        s_next.txd = ((s_next.tx_st == TX_SHIFT) ? s_next.tx_sh[0] : 1'b1)
                   ^ s_next.ctl1[`UAB_C1_INV];

        // line run length for idle and break
        if (line != s_reg.rx_prev) begin
            s_next.run = '0;
        end else if (baud_tick && s_reg.run != `UAB_RUN_MAX) begin
            s_next.run = s_reg.run + 8'h01;
        end
        s_next.rx_prev = line;
        if (s_reg.rx_on && s_reg.rx_prev && !line) begin
            set_f[`UAB_F_EDGE] = 1'b1;
        end
        if (s_reg.rx_on && !line && s_next.run == `UAB_BRK_RX
            && s_reg.run != `UAB_BRK_RX) begin
            set_f[`UAB_F_BRK] = 1'b1;
        end
        if (s_reg.rx_on && line && s_reg.idle_arm
            && s_next.run == idle_ticks && s_reg.run != idle_ticks) begin
            set_f[`UAB_F_IDLE] = 1'b1;
            s_next.idle_arm = 1'b0;
            if (!s_reg.ctl1[`UAB_C1_WAKE]) begin
                s_next.sleep = 1'b0;
            end
        end

        // receiver, three votes mid-bit
        unique case (s_reg.rx_st)
            RX_IDLE: begin
                if (baud_tick && !line) begin
                    s_next.rx_st    = RX_BUSY;
                    s_next.rx_sub   = '0;
                    s_next.rx_idx   = '0;
                    s_next.rx_ones  = '0;
                    s_next.rx_noise = 1'b0;
                end
            end
            RX_BUSY: begin
                if (baud_tick) begin
                    s_next.rx_sub = s_reg.rx_sub + 4'h1;
                    if (s_reg.rx_sub == `UAB_SMP_A
                        || s_reg.rx_sub == `UAB_SMP_B) begin
                        s_next.rx_ones = s_reg.rx_ones + {1'b0, line};
                    end
                    if (s_reg.rx_sub == `UAB_SMP_C) begin
                        ones = s_reg.rx_ones + {1'b0, line};
                        bitv = ones[1];
                        noisy = (ones != 2'h0) && (ones != 2'h3);
                        s_next.rx_ones = '0;
                        s_next.rx_noise = s_reg.rx_noise | noisy;
                        if (s_reg.rx_idx == '0) begin
                            // a high vote was a glitch, not a start bit
                            if (bitv) begin
                                s_next.rx_st = RX_IDLE;
                            end
                        end else if (s_reg.rx_idx == stop_ix) begin
                            s_next.rx_st = RX_IDLE;
                            s_next.idle_arm = 1'b1;
                            d = nine ? s_reg.rx_sh
                                     : {1'b0, s_reg.rx_sh[8:1]};
                            msb = nine ? d[8] : d[7];
                            if (!s_reg.sleep
                                || (s_reg.ctl1[`UAB_C1_WAKE] && msb)) begin
                                s_next.sleep = 1'b0;
                                if (s_reg.rx_full) begin
                                    set_f[`UAB_F_OR] = 1'b1;
                                end else begin
                                    s_next.rx_data = d;
                                    s_next.rx_full = 1'b1;
                                    set_f[`UAB_F_RDRF] = 1'b1;
                                    set_f[`UAB_F_NF] = s_next.rx_noise;
                                    set_f[`UAB_F_FE] = !bitv;
                                    set_f[`UAB_F_PF] =
                                        s_reg.ctl1[`UAB_C1_PAR]
                                        && par_bit(d,
                                        s_reg.ctl1[`UAB_C1_ODD]);
                                end
                            end
                        end else begin
                            s_next.rx_sh = {bitv, s_reg.rx_sh[8:1]};
                        end
                    end
                    if (s_reg.rx_sub == `UAB_SUB_LAST) begin
                        s_next.rx_idx = s_reg.rx_idx + 4'h1;
                    end
                end
            end
            default: s_next.rx_st = RX_IDLE;
        endcase
        if (!s_reg.rx_on) begin
            s_next.rx_st = RX_IDLE;
        end

        // new events win over a same-cycle clear
        s_next.stat = (s_reg.stat & ~clr_f) | set_f;
        s_next.irq = |(s_next.stat & {s_next.brk_ie, s_next.edge_ie,
                                      s_next.mask});
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg         <= '0;
            s_reg.div_lo  <= `UAB_BDL_RST;
            s_reg.divisor <= `UAB_DIV_RST;
            s_reg.tx_st   <= TX_IDLE;
            s_reg.rx_st   <= RX_IDLE;
            s_reg.txd     <= 1'b1;
            s_reg.rx_sync <= 2'h3;
            s_reg.rx_prev <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd_data;
    assign txd_pin = s_reg.txd;
    assign irq     = s_reg.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence tx_load;
        $rose(s_reg.tx_st == TX_SHIFT);
    endsequence

    a_div_coherent: assert property (
        (ce && wr_en && addr == `UAB_A_BDL) |=>
        s_reg.divisor == {$past(s_reg.div_hi_buf), $past(wr_data[7:0])})
        else $error("divisor not loaded from both halves");

    a_high_buffered: assert property (
        (ce && wr_en && addr == `UAB_A_BDH) |=>
        s_reg.divisor == $past(s_reg.divisor))
        else $error("high byte changed working divisor");

    a_gen_idle: assert property (
        (!s_reg.tx_on && !s_reg.rx_on) [*2] |-> !baud_tick)
        else $error("divider ticks with both paths off");

    a_irq_break: assert property (
        (s_reg.stat[`UAB_F_BRK] && s_reg.brk_ie) |-> irq)
        else $error("break flag enabled but no interrupt");

    a_irq_edge: assert property (
        (s_reg.stat[`UAB_F_EDGE] && s_reg.edge_ie) |-> irq)
        else $error("edge flag enabled but no interrupt");

    a_tdre_on_load: assert property (
        $fell(s_reg.tx_full) |-> s_reg.stat[`UAB_F_TDRE])
        else $error("holding emptied without flag");

    a_brk_frame: assert property (
        (tx_load and s_reg.tx_cnt == `UAB_BRK_TX) |-> s_reg.tx_sh == '0)
        else $error("break frame not all zero");

    a_frame_shape: assert property (
        (tx_load and s_reg.tx_cnt == `UAB_BITS8) |->
        !s_reg.tx_sh[0] && s_reg.tx_sh[9])
        else $error("frame lacks start or stop bit");

    a_par_gen: assert property (
        (tx_load and s_reg.tx_cnt == `UAB_BITS8
         and s_reg.ctl1[`UAB_C1_PAR]) |->
        (^s_reg.tx_sh[8:1]) == s_reg.ctl1[`UAB_C1_ODD])
        else $error("wrong transmit parity");

    a_tx_idle_high: assert property (
        (s_reg.tx_st == TX_IDLE) |-> txd_pin != s_reg.ctl1[`UAB_C1_INV])
        else $error("idle line level wrong");

    a_tx_bit_edge: assert property (
        ($changed(txd_pin) && s_reg.tx_st == TX_SHIFT
         && $stable(s_reg.ctl1)) |-> s_reg.tx_sub == '0)
        else $error("line moved inside a bit");

endmodule

// ===== uab_peer.sv
`timescale 1ns/100ps
module uab_peer (
    // serial line
    input  wire logic txd,
    output logic      rxd
);
    // released line rests high, as with a pull-up
    initial rxd = 1'b1;
    // start, eight data bits lsb first, stop
    task automatic send(input logic [7:0] b, input int per);
        int i;
        rxd = 1'b0;
        #(per);
        for (i = 0; i < 8; i++) begin
            rxd = b[i];
            #(per);
        end
        rxd = 1'b1;
        #(per);
    endtask
    // line low for thirteen bit times, past the detect limit
    task automatic brk(input int per);
        rxd = 1'b0;
        #(per * 13);
        rxd = 1'b1;
        #(per * 2);
    endtask
    // mid-bit sampling from the start edge
    task automatic recv(output logic [7:0] b, input int per);
        int i;
        @(negedge txd);
        #(per * 3 / 2);
        for (i = 0; i < 8; i++) begin
            b[i] = txd;
            #(per);
        end
    endtask
endmodule

// ===== uab_top_tb.sv
`timescale 1ns/100ps
`include "uab_regs.svh"
module uab_top_tb;
    import uab_pkg::*;
    logic               ref_clk;
    logic               rst;
    logic               ce;
    logic [`UAB_AW-1:0] addr;
    logic [`UAB_DW-1:0] wr_data;
    logic               wr_en;
    logic               rd_en;
    logic [`UAB_DW-1:0] rd_data;
    logic               rxd_pin;
    logic               txd_pin;
    logic               irq;
    logic [`UAB_DW-1:0] v;
    logic [7:0]         b;
    int                 mismatches;
    int                 samples_checked;
    int                 cyc;

    uab_top uab_top_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .rxd_pin(rxd_pin), .txd_pin(txd_pin), .irq(irq));
    uab_peer uab_peer_i (.txd(txd_pin), .rxd(rxd_pin));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // irq is registered: let two edges land first
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({15'h0000, irq}, {15'h0000, e});
    endtask

    task automatic print_verdict;
        $display("mismatches=%0d samples_checked=%0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // whole run needs well under this many cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            print_verdict;
        end
    end

    initial begin
        mismatches = 0;
        samples_checked = 0;
        cyc = 0;
        rst = 1'b1;
        ce = 1'b1;
        addr = '0;
        wr_data = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk_rd(`UAB_A_BDL, 16'h0004);
        chk_rd(`UAB_A_DIVR, 16'h0004);
        chk_rd(`UAB_A_BDH, 16'h0000);
        wr(`UAB_A_BDH, 16'h0001);
        chk_rd(`UAB_A_DIVR, 16'h0004);
        wr(`UAB_A_BDL, 16'h0002);
        chk_rd(`UAB_A_DIVR, 16'h0102);
        wr(`UAB_A_BDH, 16'h0000);
        // bit period is 16 * divisor clocks of 40 ns
        for (int d = 2; d >= 1; d--) begin
            wr(`UAB_A_BDL, d[15:0]);
            wr(`UAB_A_CTL2, 16'h0008);
            wr(`UAB_A_DATA, 16'h005A + 16'(d));
            uab_peer_i.recv(b, 640 * d);
            chk({8'h00, b}, 16'h005A + 16'(d));
        end
        for (int p = 0; p < 2; p++) begin
            wr(`UAB_A_CTL1, 16'h0002 | p[15:0]);
            wr(`UAB_A_DATA, 16'h0003);
            uab_peer_i.recv(b, 640);
            chk({8'h00, b}, (p == 1) ? 16'h0083 : 16'h0003);
        end
        // break must still be low in its thirteenth bit
        wr(`UAB_A_CTL2, 16'h0009);
        @(negedge txd_pin);
        #(640 * 25 / 2);
        chk({15'h0000, txd_pin}, 16'h0000);
        wr(`UAB_A_CTL2, 16'h0008);
        repeat (80) @(posedge ref_clk);
        // nine-bit char: ninth bit sampled right after the eighth
        wr(`UAB_A_CTL1, 16'h0010);
        wr(`UAB_A_DATA, 16'h01A5);
        uab_peer_i.recv(b, 640);
        chk({7'h00, txd_pin, b}, 16'h01A5);
        wr(`UAB_A_CTL1, 16'h0004);
        repeat (40) @(posedge ref_clk);
        chk({15'h0000, txd_pin}, 16'h0000);
        wr(`UAB_A_CTL1, 16'h0000);
        wr(`UAB_A_STAT, 16'h03FF);
        wr(`UAB_A_MASK, 16'h0004);
        wr(`UAB_A_CTL2, 16'h000C);
        uab_peer_i.send(8'hA3, 640);
        repeat (40) @(posedge ref_clk);
        chk_irq(1'b1);
        chk_rd(`UAB_A_DATA, 16'h00A3);
        wr(`UAB_A_STAT, 16'h0004);
        chk_irq(1'b0);
        wr(`UAB_A_MASK, 16'h0000);
        wr(`UAB_A_BDH, 16'h0040);
        chk_irq(1'b1);
        wr(`UAB_A_STAT, 16'h0100);
        chk_irq(1'b0);
        wr(`UAB_A_BDH, 16'h0080);
        uab_peer_i.brk(640);
        rd(`UAB_A_STAT, v);
        chk(v & 16'h0200, 16'h0200);
        chk_irq(1'b1);
        wr(`UAB_A_BDH, 16'h0000);
        chk_irq(1'b0);
        // zero divisor: the queued char must wait for a new divisor
        wr(`UAB_A_STAT, 16'h03FF);
        wr(`UAB_A_BDL, 16'h0000);
        wr(`UAB_A_DATA, 16'h0011);
        repeat (400) @(posedge ref_clk);
        rd(`UAB_A_STAT, v);
        chk(v & 16'h0002, 16'h0000);
        wr(`UAB_A_BDL, 16'h0001);
        repeat (400) @(posedge ref_clk);
        rd(`UAB_A_STAT, v);
        chk(v & 16'h0002, 16'h0002);
        print_verdict;
    end
endmodule
